// ### core/mviu_top.sv
// Multilevel vectored interrupt unit: arming, priority, vectoring and inhibit.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mviu_top
   import mviu_pkg::*;
#(
   parameter int          NUM_LEVELS    = 16,
   parameter int          GROUP_SIZE    = 16,
   parameter logic [5:0]  DEV_ADDR_BASE = 6'h10,
   parameter logic [15:0] VECTOR_BASE   = 16'h0100
) (
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output var  logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output var  logic                  s_axi_wready,
   output var  logic [1:0]            s_axi_bresp,
   output var  logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output var  logic                  s_axi_arready,
   output var  logic [31:0]           s_axi_rdata,
   output var  logic [1:0]            s_axi_rresp,
   output var  logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  powerFail,
   input  wire logic                  consoleButton,
   input  wire logic [NUM_LEVELS-3:0] irqReq,
   input  wire logic                  irqTimingClock,
   input  wire logic                  cpuInstrEnd,
   input  wire logic                  cpuVecAck,
   input  wire logic                  cpuVecDone,
   input  wire logic                  vectorIsJumpFlag,
   output logic                       vecValid,
   output logic [15:0]                vecAddr,
   output logic                       unitInhibited
);
   localparam int LVL_W      = $clog2(NUM_LEVELS);
   localparam int NUM_GROUPS = NUM_LEVELS / GROUP_SIZE;

   // The selector and registers assume at most 32 levels split into whole groups.
   if (NUM_LEVELS < 8 || NUM_LEVELS > 32 || (NUM_LEVELS % GROUP_SIZE) != 0 ||
       (GROUP_SIZE != 8 && GROUP_SIZE != 16)) begin : g_bad_config
      $error("mviu_top: unsupported level count or group size");
   end

   function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = oldVal;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = newVal[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [15:0] vectorOf(input logic [LVL_W-1:0] lvl);
      return VECTOR_BASE + 16'(MVIU_VEC_STRIDE) * 16'(lvl);
   endfunction

   // Returns the group index of an arm register address, or NUM_GROUPS if none.
   function automatic int armGroupOf(input logic [7:0] addr);
      int g;
      g = NUM_GROUPS;
      for (int i = 0; i < NUM_GROUPS; i++) begin
         if (addr == MVIU_ARM_OFS + 8'(4 * i)) begin
            g = i;
         end
      end
      return g;
   endfunction

   mviu_reg_if rb ();

   mviu_axil_slave u_slave (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .rb      (rb)
   );

   logic                  sysEnable_reg;
   logic [NUM_LEVELS-1:0] arm_reg;
   logic [NUM_LEVELS-1:0] reqSync_reg;
   logic                  timingPrev_reg;
   logic                  inhibit_reg;
   mviu_state_t           state_reg;
   mviu_state_t           state_next;
   logic [LVL_W-1:0]      curLevel_reg;
   logic [15:0]           lastVec_reg;
   logic                  lastJump_reg;
   logic [NUM_LEVELS-1:0] rawReq;
   logic [NUM_LEVELS-1:0] armedReq;
   logic                  tick;
   logic                  selFound;
   logic [LVL_W-1:0]      selLevel;
   logic                  ctrlWrite;
   logic                  endInhibit;
   logic                  jumpSeen;
   int                    wrGroup;

   // Power failure sits on the top priority, the console button on the bottom.
   assign rawReq   = {consoleButton, irqReq, powerFail};
   assign tick     = irqTimingClock && !timingPrev_reg;
   assign armedReq = reqSync_reg & arm_reg;

   assign ctrlWrite  = rb.wrEn && rb.wrAddr == MVIU_CTRL_OFS;
   assign endInhibit = ctrlWrite && rb.wrStrb[0] && rb.wrData[MVIU_CTRL_ENDINH_BIT];
   assign jumpSeen   = state_reg == MVIU_ST_EXEC && cpuVecDone && vectorIsJumpFlag;
   assign wrGroup    = armGroupOf(rb.wrAddr);

   mviu_prio_sel #(
      .NUM_LEVELS (NUM_LEVELS),
      .LVL_W      (LVL_W)
   ) u_sel (
      .armedReq (armedReq),
      .found    (selFound),
      .level    (selLevel)
   );

   // The timing clock arrives synchronous to mclk, so one flop finds its rising edge.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         timingPrev_reg <= 1'b0;
      end else begin
         timingPrev_reg <= irqTimingClock;
      end
   end

   // A request raised mid-period is sampled at the following tick and only joins the contest at the tick after that.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reqSync_reg <= '0;
      end else if (tick) begin
         reqSync_reg <= rawReq;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sysEnable_reg <= MVIU_ENABLE_RST;
      end else if (ctrlWrite && rb.wrStrb[0]) begin
         sysEnable_reg <= rb.wrData[MVIU_CTRL_ENABLE_BIT];
      end
   end

   // Arming stays writable in every state, the inhibited one included.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         arm_reg <= NUM_LEVELS'(MVIU_ARM_RST);
      end else if (rb.wrEn && wrGroup < NUM_GROUPS) begin
         arm_reg[wrGroup*GROUP_SIZE +: GROUP_SIZE] <= GROUP_SIZE'(mergeBytes(
            32'(arm_reg[wrGroup*GROUP_SIZE +: GROUP_SIZE]), rb.wrData, rb.wrStrb));
      end
   end

   // A jump reported in the same cycle as an end-of-inhibit write keeps the unit inhibited.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         inhibit_reg <= 1'b0;
      end else if (jumpSeen) begin
         inhibit_reg <= 1'b1;
      end else if (endInhibit) begin
         inhibit_reg <= 1'b0;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         MVIU_ST_IDLE: begin
            if (tick && selFound && sysEnable_reg && !inhibit_reg) begin
               state_next = MVIU_ST_WAIT;
            end
         end
         MVIU_ST_WAIT: begin
            // A level disarmed or withdrawn while waiting is dropped, not vectored.
            if (!sysEnable_reg || inhibit_reg || !armedReq[curLevel_reg]) begin
               state_next = MVIU_ST_IDLE;
            end else if (cpuInstrEnd) begin
               state_next = MVIU_ST_OFFER;
            end
         end
         MVIU_ST_OFFER: begin
            if (cpuVecAck) begin
               state_next = MVIU_ST_EXEC;
            end
         end
         MVIU_ST_EXEC: begin
            if (cpuVecDone) begin
               state_next = MVIU_ST_IDLE;
            end
         end
         default: begin
            state_next = MVIU_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= MVIU_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         curLevel_reg <= '0;
      end else if (state_reg == MVIU_ST_IDLE && state_next == MVIU_ST_WAIT) begin
         curLevel_reg <= selLevel;
      end
   end

   // The vector stays on the exchange bus from offer until the processor takes it.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         vecValid <= 1'b0;
         vecAddr  <= MVIU_VECTOR_RST;
      end else if (state_reg == MVIU_ST_WAIT && state_next == MVIU_ST_OFFER) begin
         vecValid <= 1'b1;
         vecAddr  <= vectorOf(curLevel_reg);
      end else if (state_reg == MVIU_ST_OFFER && cpuVecAck) begin
         vecValid <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         unitInhibited <= 1'b0;
      end else if (jumpSeen) begin
         unitInhibited <= 1'b1;
      end else if (endInhibit) begin
         unitInhibited <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lastVec_reg  <= MVIU_VECTOR_RST;
         lastJump_reg <= 1'b0;
      end else if (state_reg == MVIU_ST_EXEC && cpuVecDone) begin
         lastVec_reg  <= vecAddr;
         lastJump_reg <= vectorIsJumpFlag;
      end
   end

   assign rb.wrOk = rb.wrAddr == MVIU_CTRL_OFS || wrGroup < NUM_GROUPS;

   always_comb begin
      int rdGroup;
      rdGroup   = armGroupOf(rb.rdAddr);
      rb.rdData = 32'h0000_0000;
      rb.rdOk   = 1'b1;
      case (rb.rdAddr)
         MVIU_CTRL_OFS: begin
            rb.rdData[MVIU_CTRL_ENABLE_BIT] = sysEnable_reg;
         end
         MVIU_STATUS_OFS: begin
            rb.rdData[MVIU_ST_INHIBIT_BIT] = inhibit_reg;
            rb.rdData[MVIU_ST_VALID_BIT]   = vecValid;
            rb.rdData[MVIU_ST_BUSY_BIT]    = state_reg != MVIU_ST_IDLE;
            rb.rdData[MVIU_ST_LEVEL_LSB +: 8] = 8'(curLevel_reg);
         end
         MVIU_PEND_OFS: begin
            rb.rdData = 32'(reqSync_reg);
         end
         MVIU_ARMPEND_OFS: begin
            rb.rdData = 32'(armedReq);
         end
         MVIU_LASTVEC_OFS: begin
            rb.rdData[15:0] = lastVec_reg;
            rb.rdData[MVIU_LASTVEC_JUMP_BIT] = lastJump_reg;
         end
         default: begin
            if (rdGroup < NUM_GROUPS) begin
               rb.rdData = 32'(arm_reg[rdGroup*GROUP_SIZE +: GROUP_SIZE]);
               rb.rdData[MVIU_ARM_DEVADDR_LSB +: 6] = DEV_ADDR_BASE + 6'(rdGroup);
            end else begin
               rb.rdOk = 1'b0;
            end
         end
      endcase
   end
endmodule // mviu_top
`default_nettype wire

// ### core/mviu_pkg.sv
// Shared constants and types of the multilevel vectored interrupt unit.
package mviu_pkg;

   // Register byte offsets on the control bus.
   localparam logic [7:0] MVIU_CTRL_OFS      = 8'h00;
   localparam logic [7:0] MVIU_STATUS_OFS    = 8'h04;
   localparam logic [7:0] MVIU_PEND_OFS      = 8'h08;
   localparam logic [7:0] MVIU_ARMPEND_OFS   = 8'h0c;
   localparam logic [7:0] MVIU_LASTVEC_OFS   = 8'h10;
   localparam logic [7:0] MVIU_ARM_OFS       = 8'h20;

   // Control register fields.
   localparam int         MVIU_CTRL_ENABLE_BIT  = 0;
   localparam int         MVIU_CTRL_ENDINH_BIT  = 1;
   localparam logic       MVIU_ENABLE_RST       = 1'b0;

   // Status, arm and last-vector register fields.
   localparam int         MVIU_ST_INHIBIT_BIT   = 0;
   localparam int         MVIU_ST_VALID_BIT     = 1;
   localparam int         MVIU_ST_BUSY_BIT      = 2;
   localparam int         MVIU_ST_LEVEL_LSB     = 8;
   localparam int         MVIU_ARM_DEVADDR_LSB  = 16;
   localparam int         MVIU_LASTVEC_JUMP_BIT = 16;

   // Reset values.
   localparam logic [31:0] MVIU_ARM_RST     = 32'h0000_0000;
   localparam logic [15:0] MVIU_VECTOR_RST  = 16'h0000;

   // Each level owns a pair of consecutive locations.
   localparam int         MVIU_VEC_STRIDE = 2;

   // AXI response codes.
   localparam logic [1:0] MVIU_RESP_OKAY   = 2'b00;
   localparam logic [1:0] MVIU_RESP_SLVERR = 2'b10;

   typedef enum logic [3:0] {
      MVIU_ST_IDLE  = 4'b0001,
      MVIU_ST_WAIT  = 4'b0010,
      MVIU_ST_OFFER = 4'b0100,
      MVIU_ST_EXEC  = 4'b1000
   } mviu_state_t;

endpackage

// ### core/mviu_reg_if.sv
// Register access strobes between the bus slave and the unit core.
`timescale 1ns/1ps
`default_nettype none
interface mviu_reg_if;
   logic        wrEn;
   logic [7:0]  wrAddr;
   logic [31:0] wrData;
   logic [3:0]  wrStrb;
   logic        wrOk;
   logic [7:0]  rdAddr;
   logic [31:0] rdData;
   logic        rdOk;

   modport slave (output wrEn, output wrAddr, output wrData, output wrStrb, input wrOk,
                  output rdAddr, input rdData, input rdOk);
   modport core  (input wrEn, input wrAddr, input wrData, input wrStrb, output wrOk,
                  input rdAddr, output rdData, output rdOk);
endinterface
`default_nettype wire

// ### core/mviu_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/1ps
`default_nettype none
module mviu_axil_slave
   import mviu_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output var  logic        wready,
   output var  logic [1:0]  bresp,
   output var  logic        bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output var  logic        arready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   output var  logic        rvalid,
   input  wire logic        rready,
   mviu_reg_if.slave        rb
);
   logic [7:0]  awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0]  wStrb_reg;
   logic [7:0]  arAddr_reg;
   logic        rdPend_reg;

   // Both halves are held until the response, so the core sees one strobe per write.
   assign rb.wrEn   = !awready && !wready && !bvalid;
   assign rb.wrAddr = awAddr_reg;
   assign rb.wrData = wData_reg;
   assign rb.wrStrb = wStrb_reg;
   assign rb.rdAddr = arAddr_reg;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         awready    <= 1'b1;
         wready     <= 1'b1;
         bvalid     <= 1'b0;
         bresp      <= MVIU_RESP_OKAY;
         awAddr_reg <= 8'h00;
         wData_reg  <= 32'h0000_0000;
         wStrb_reg  <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awAddr_reg <= awaddr;
            awready    <= 1'b0;
         end
         if (wvalid && wready) begin
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
            wready    <= 1'b0;
         end
         if (rb.wrEn) begin
            bvalid <= 1'b1;
            bresp  <= rb.wrOk ? MVIU_RESP_OKAY : MVIU_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         arready    <= 1'b1;
         rvalid     <= 1'b0;
         rdata      <= 32'h0000_0000;
         rresp      <= MVIU_RESP_OKAY;
         arAddr_reg <= 8'h00;
         rdPend_reg <= 1'b0;
      end else begin
         if (arvalid && arready) begin
            arAddr_reg <= araddr;
            arready    <= 1'b0;
            rdPend_reg <= 1'b1;
         end
         if (rdPend_reg) begin
            rdPend_reg <= 1'b0;
            rvalid     <= 1'b1;
            rdata      <= rb.rdData;
            rresp      <= rb.rdOk ? MVIU_RESP_OKAY : MVIU_RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule // mviu_axil_slave
`default_nettype wire

// ### core/mviu_prio_sel.sv
// Fixed-order priority selector: the lowest level number wins.
`timescale 1ns/1ps
`default_nettype none
module mviu_prio_sel #(
   parameter int NUM_LEVELS = 16,
   parameter int LVL_W      = 4
) (
   input  wire logic [NUM_LEVELS-1:0] armedReq,
   output var  logic                  found,
   output var  logic [LVL_W-1:0]      level
);
   // A level index too narrow for the request vector would alias two levels onto one vector.
   if (LVL_W < 1 || NUM_LEVELS < 2 || NUM_LEVELS > (1 << LVL_W)) begin : g_bad_width
      $error("mviu_prio_sel: level index too narrow for the level count");
   end

   always_comb begin
      found = 1'b0;
      level = '0;
      for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
         if (armedReq[i]) begin
            found = 1'b1;
            level = LVL_W'(i);
         end
      end
   end
endmodule // mviu_prio_sel
`default_nettype wire

// ### verif/mviu_top_chk.sv
// Concurrent checks on the ports of the interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module mviu_top_chk
   import mviu_pkg::*;
#(
   parameter int          NUM_LEVELS  = 16,
   parameter logic [15:0] VECTOR_BASE = 16'h0100
) (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        s_axi_wvalid,
   input wire logic        cpuInstrEnd,
   input wire logic        cpuVecAck,
   input wire logic        cpuVecDone,
   input wire logic        vectorIsJumpFlag,
   input wire logic        vecValid,
   input wire logic [15:0] vecAddr,
   input wire logic        unitInhibited
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_vec_pair_slot: assert property (
      vecValid |-> vecAddr[0] == 1'b0 && vecAddr >= VECTOR_BASE && vecAddr < VECTOR_BASE + 16'(2 * NUM_LEVELS))
      else $error("vector outside the level table");
   a_offer_after_end: assert property ($rose(vecValid) |-> $past(cpuInstrEnd))
      else $error("vector offered before the instruction ended");
   a_offer_holds: assert property (vecValid && !cpuVecAck |=> vecValid && $stable(vecAddr))
      else $error("vector dropped or changed before acknowledge");
   a_ack_takes: assert property (vecValid && cpuVecAck |=> !vecValid)
      else $error("vector still offered after acknowledge");
   a_jump_inhibits: assert property (cpuVecDone && vectorIsJumpFlag |=> unitInhibited)
      else $error("jump at vector did not inhibit");
   a_inhib_blocks: assert property ($rose(vecValid) |-> !$past(unitInhibited))
      else $error("vector offered while inhibited");
   // Only a register write may end the inhibit, so a fall needs a recent write beat.
   a_inhib_until_write: assert property (
      $fell(unitInhibited) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
      else $error("inhibit ended without a write");
   a_reset_quiet: assert property (
      $past(sys_rst) |-> !vecValid && !unitInhibited && vecAddr == MVIU_VECTOR_RST)
      else $error("outputs not cleared by reset");

   c_offer: cover property ($rose(vecValid));
   c_inhibit: cover property ($rose(unitInhibited));
   c_release: cover property ($fell(unitInhibited));
endmodule // mviu_top_chk

bind mviu_top mviu_top_chk #(.NUM_LEVELS(NUM_LEVELS), .VECTOR_BASE(VECTOR_BASE)) chk_u (
   .mclk, .sys_rst, .s_axi_wvalid, .cpuInstrEnd, .cpuVecAck, .cpuVecDone, .vectorIsJumpFlag,
   .vecValid, .vecAddr, .unitInhibited);
`default_nettype wire

// ### verif/mviu_cpu_model.sv
// Processor-side partner: timing ticks, instruction ends, vector acknowledge and completion.
`timescale 1ns/1ps
`default_nettype none
module mviu_cpu_model (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic vecValid,
   input  wire logic jumpSel,
   input  wire logic slowAck,
   output var  logic irqTimingClock,
   output var  logic cpuInstrEnd,
   output var  logic cpuVecAck,
   output var  logic cpuVecDone,
   output var  logic vectorIsJumpFlag
);
   logic [2:0] phase;
   logic       seenValid;
   always_ff @(posedge mclk) phase <= sys_rst ? 3'h0 : phase + 3'h1;
   // One tick in eight cycles keeps sampling and decision clearly apart.
   always_ff @(posedge mclk) irqTimingClock <= !sys_rst && phase == 3'h7;
   always_ff @(posedge mclk) cpuInstrEnd <= !sys_rst && phase[1:0] == 2'h1;
   always_ff @(posedge mclk) seenValid <= !sys_rst && vecValid;
   always_ff @(posedge mclk) cpuVecAck <= !sys_rst && vecValid && !cpuVecAck && (!slowAck || seenValid);
   // Exactly one instruction runs at the vector, then the program resumes.
   always_ff @(posedge mclk) cpuVecDone <= !sys_rst && vecValid && cpuVecAck;
   // Away from the done pulse the flag shows the opposite, so a late sample is caught.
   always_ff @(posedge mclk) vectorIsJumpFlag <= (vecValid && cpuVecAck) ? jumpSel : !jumpSel;
endmodule // mviu_cpu_model
`default_nettype wire

// ### verif/mviu_top_test.sv
// Self-checking bench for the multilevel vectored interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module mviu_top_test
   import mviu_pkg::*;
;
   localparam logic [15:0] VBASE = 16'h0100;
   localparam logic [5:0]  DEVA  = 6'h10;
   logic        mclk = 1'b0, sys_rst = 1'b1, jumpSel = 1'b0, slowAck = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rd, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [15:0] lvlReq = 16'h0, vecAddr;
   logic [1:0]  rr, s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        irqTimingClock, cpuInstrEnd, cpuVecAck, cpuVecDone, vectorIsJumpFlag, vecValid, unitInhibited;
   int          n_errors = 0, checks_done = 0;

   always #2 mclk = ~mclk;

   mviu_top #(.DEV_ADDR_BASE(DEVA), .VECTOR_BASE(VBASE)) dut_u (
      .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .powerFail(lvlReq[0]), .consoleButton(lvlReq[15]), .irqReq(lvlReq[14:1]), .irqTimingClock,
      .cpuInstrEnd, .cpuVecAck, .cpuVecDone, .vectorIsJumpFlag, .vecValid, .vecAddr, .unitInhibited);
   mviu_cpu_model cpu_u (.mclk, .sys_rst, .vecValid, .jumpSel, .slowAck, .irqTimingClock,
      .cpuInstrEnd, .cpuVecAck, .cpuVecDone, .vectorIsJumpFlag);

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      int   t;
      aw = 1'b1;
      w = 1'b1;
      t = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         t++;
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1 && t < 60);
      chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int t;
      t = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         t++;
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 60);
      chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wait_vec(input logic [15:0] e);
      int t;
      t = 0;
      do begin
         @(posedge mclk);
         t++;
      end while (vecValid !== 1'b1 && t < 100);
      chk("vecValid", 32'h1, {31'h0, vecValid});
      chk("vecAddr", {16'h0, e}, {16'h0, vecAddr});
   endtask

   task automatic quiet(input int n);
      int c;
      c = 0;
      repeat (n) begin
         @(posedge mclk);
         if (vecValid !== 1'b0) c++;
      end
      chk("noOffer", 32'h0, c);
   endtask

   // All requests are withdrawn, served or not, then 40 cycles pass before the next step.
   task automatic settle;
      lvlReq <= 16'h0;
      repeat (40) @(posedge mclk);
   endtask

   task automatic t_reset_regs;
      axi_rd(MVIU_CTRL_OFS, rd, rr);
      chk("ctrl", 32'h0, rd);
      axi_rd(MVIU_STATUS_OFS, rd, rr);
      chk("status", 32'h0, rd);
      axi_rd(MVIU_ARM_OFS, rd, rr);
      chk("arm", {10'h0, DEVA, 16'h0}, rd);
      axi_wr(MVIU_ARM_OFS, 32'h0000_a5c3, MVIU_RESP_OKAY);
      axi_rd(MVIU_ARM_OFS, rd, rr);
      chk("armBack", {10'h0, DEVA, 16'ha5c3}, rd);
      axi_wr(8'h3c, 32'h1, MVIU_RESP_SLVERR);
      axi_rd(8'h3c, rd, rr);
      chk("rresp", {30'h0, MVIU_RESP_SLVERR}, {30'h0, rr});
   endtask

   task automatic t_gating;
      axi_wr(MVIU_ARM_OFS, 32'h0000_ffff, MVIU_RESP_OKAY);
      lvlReq <= 16'h0008;
      quiet(60);
      axi_wr(MVIU_ARM_OFS, 32'h0000_fff7, MVIU_RESP_OKAY);
      axi_wr(MVIU_CTRL_OFS, 32'h1, MVIU_RESP_OKAY);
      quiet(60);
      axi_rd(MVIU_PEND_OFS, rd, rr);
      chk("pend", 32'h8, rd);
      axi_rd(MVIU_ARMPEND_OFS, rd, rr);
      chk("armPend", 32'h0, rd);
      settle();
   endtask

   task automatic t_all_vectors;
      axi_wr(MVIU_ARM_OFS, 32'h0000_ffff, MVIU_RESP_OKAY);
      for (int lvl = 0; lvl < 16; lvl++) begin
         slowAck <= lvl[0];
         lvlReq <= 16'h0001 << lvl;
         wait_vec(VBASE + 16'(MVIU_VEC_STRIDE * lvl));
         settle();
      end
   endtask

   task automatic t_priority;
      lvlReq <= 16'h8024;
      wait_vec(VBASE + 16'h0004);
      settle();
      axi_wr(MVIU_ARM_OFS, 32'h0000_8020, MVIU_RESP_OKAY);
      lvlReq <= 16'h8024;
      wait_vec(VBASE + 16'h000a);
      settle();
   endtask

   task automatic t_jump_inhibit;
      axi_wr(MVIU_ARM_OFS, 32'h0000_ffff, MVIU_RESP_OKAY);
      jumpSel <= 1'b1;
      lvlReq <= 16'h0010;
      wait_vec(VBASE + 16'h0008);
      repeat (6) @(posedge mclk);
      chk("inhibit", 32'h1, {31'h0, unitInhibited});
      lvlReq <= 16'h0002;
      quiet(60);
      axi_wr(MVIU_ARM_OFS, 32'h0000_0002, MVIU_RESP_OKAY);
      axi_rd(MVIU_STATUS_OFS, rd, rr);
      chk("stInhibit", 32'h1, {31'h0, rd[MVIU_ST_INHIBIT_BIT]});
      jumpSel <= 1'b0;
      axi_wr(MVIU_CTRL_OFS, 32'h3, MVIU_RESP_OKAY);
      wait_vec(VBASE + 16'h0002);
      settle();
   endtask

   // A reset in mid-run must drop an inhibit and all configuration at once.
   task automatic t_mid_reset;
      jumpSel <= 1'b1;
      lvlReq <= 16'h0002;
      wait_vec(VBASE + 16'h0002);
      repeat (6) @(posedge mclk);
      chk("inhibit2", 32'h1, {31'h0, unitInhibited});
      axi_rd(MVIU_LASTVEC_OFS, rd, rr);
      chk("lastVec", {15'h0, 1'b1, VBASE + 16'h0002}, rd);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      chk("rstInhibit", 32'h0, {31'h0, unitInhibited});
      axi_rd(MVIU_CTRL_OFS, rd, rr);
      chk("rstCtrl", 32'h0, rd);
      axi_rd(MVIU_ARM_OFS, rd, rr);
      chk("rstArm", {10'h0, DEVA, 16'h0}, rd);
      quiet(40);
      jumpSel <= 1'b0;
      settle();
   endtask

   task automatic tally_and_finish;
      if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_reset_regs();
      t_gating();
      t_all_vectors();
      t_priority();
      t_jump_inhibit();
      t_mid_reset();
      tally_and_finish();
   end

   // The scenarios need under two thousand cycles; this span leaves a wide margin.
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      tally_and_finish();
   end
endmodule // mviu_top_test
`default_nettype wire
